// File: verilog/scg_pkg.sv
// Shared constants for the sample-clock generator control block
package scg_pkg;
	// Register offsets
	localparam logic [5:0]  ADDR_GEN1_MODE  = 6'h10;
	localparam logic [5:0]  ADDR_GEN1_RATE  = 6'h11;
	localparam logic [5:0]  ADDR_GEN1_PHASE = 6'h12;
	localparam logic [5:0]  ADDR_GEN2_MODE  = 6'h13;
	// Values after reset
	localparam logic [15:0] GEN1_MODE_RESET  = 16'h00ff;
	localparam logic [15:0] GEN1_RATE_RESET  = 16'hbb80;
	localparam logic [15:0] GEN1_PHASE_RESET = 16'h0000;
	localparam logic [15:0] GEN2_MODE_RESET  = 16'h00ff;
	// Writable bits; reserved bits read as zero
	localparam logic [15:0] MODE_WRITE_MASK  = 16'hfcff;
	localparam logic [15:0] PHASE_WRITE_MASK = 16'h01ff;
	// Mode and phase field positions
	localparam int BIT_REF   = 15;
	localparam int BIT_VID   = 14;
	localparam int BIT_PLLG  = 13;
	localparam int BIT_P200  = 12;
	localparam int BIT_X87   = 11;
	localparam int BIT_C128  = 10;
	localparam int BIT_PAL   = 7;
	localparam int BIT_PHDIR = 8;
	// Bit clock table
	localparam logic [15:0] BITCLK_STEP_HZ = 16'h0960;
	localparam logic [15:0] BITCLK_PLUS_HZ = 16'h00c8;
	localparam logic [3:0]  BITCLK_TOP     = 4'hb;
	localparam logic [3:0]  NIBBLE_ONES    = 4'hf;
	// Video lock bases
	localparam logic [15:0] BASE_48000 = 16'hbb80;
	localparam logic [15:0] BASE_32000 = 16'h7d00;
	localparam logic [15:0] BASE_44100 = 16'hac44;
	localparam logic [15:0] BASE_29400 = 16'h72d8;
	localparam logic [15:0] BASE_44056 = 16'hac18;
	localparam logic [3:0]  DIV_TOP    = 4'h7;
	// Normal lock conversion rates; codes 7 to 10 carry the 8/7 factor
	localparam logic [3:0]  NORMAL_TOP = 4'ha;
	localparam logic [3:0]  NORMAL_X87 = 4'h7;
	localparam logic [15:0] NORMAL_HZ [0:10] = '{16'h1c20, 16'h20d0, 16'h2328,
		16'h2580, 16'h2bc0, 16'h2ee0, 16'h3200, 16'h1c20, 16'h2328, 16'h2580,
		16'h2ee0};
	// Phase step rate, in kHz
	localparam int MCLK_KHZ       = 200000;
	localparam int PHASE_STEP_KHZ = 3072;
endpackage

// File: verilog/scg_phase_if.sv
// Phase stepper connection between control, tick source and stepper
`timescale 1ns/1ps
`default_nettype none
interface scg_phase_if;
	logic       load;
	logic       clear;
	logic       load_dir;
	logic [7:0] load_mag;
	logic       tick;
	logic       dir;
	logic [7:0] mag;
	logic       step;
	modport ctrl    (output load, clear, load_dir, load_mag, input dir, mag, step, tick);
	modport stepper (input load, clear, load_dir, load_mag, tick, output dir, mag, step);
	modport ticker  (output tick);
endinterface
`default_nettype wire

// File: verilog/scg_step_tick.sv
// Fractional divider giving the phase step enable pulse
`timescale 1ns/1ps
`default_nettype none
module scg_step_tick #(
	parameter int INC = scg_pkg::PHASE_STEP_KHZ,
	parameter int MOD = scg_pkg::MCLK_KHZ
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Enable out
	scg_phase_if.ticker t
);
	// Refuse rates that the 24-bit accumulator cannot serve without overflow
	if (INC <= 0 || INC >= MOD || MOD > (1 << 23)) begin : g_bad_rate
		$error("unusable INC/MOD for the step divider");
	end

	logic [23:0] acc;
	logic [23:0] next_acc;

	always_comb begin
		next_acc = acc + 24'(INC);
	end

	// Average rate is exactly INC/MOD of the clock
	always_ff @(posedge clk) begin
		if (rst) begin
			acc    <= 24'h000000;
			t.tick <= 1'b0;
		end else if (next_acc >= 24'(MOD)) begin
			acc    <= next_acc - 24'(MOD);
			t.tick <= 1'b1;
		end else begin
			acc    <= next_acc;
			t.tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: verilog/scg_phase_stepper.sv
// Pending phase shift counter
`timescale 1ns/1ps
`default_nettype none
module scg_phase_stepper (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Stepper side
	scg_phase_if.stepper p
);
	always_ff @(posedge clk) begin
		if (rst || p.clear) begin
			p.mag <= 8'h00;
			p.dir <= 1'b0;
		end else if (p.load) begin
			p.mag <= p.load_mag;
			p.dir <= p.load_dir;
		end else if (p.tick && p.mag != 8'h00) begin
			p.mag <= p.mag - 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		p.step <= !rst && !p.clear && !p.load && p.tick && p.mag != 8'h00;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_decrement;
		!p.clear && !p.load && p.tick && p.mag != 8'h00 |=> p.mag == $past(p.mag) - 8'h01;
	endproperty
	a_decrement: assert property (p_decrement) else $error("magnitude not decremented");

	property p_stop_zero;
		!p.clear && !p.load && p.mag == 8'h00 |=> p.mag == 8'h00 && $stable(p.dir) && !p.step;
	endproperty
	a_stop_zero: assert property (p_stop_zero) else $error("stepping past zero");

	property p_overwrite;
		!p.clear && p.load |=> p.mag == $past(p.load_mag) && p.dir == $past(p.load_dir);
	endproperty
	a_overwrite: assert property (p_overwrite) else $error("write not accepted");
endmodule
`default_nettype wire

// File: verilog/scg_generator_ctrl.sv
// Generator one sample-clock control registers and mode decode
`timescale 1ns/1ps
`default_nettype none
module scg_generator_ctrl (
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        SYS_RST,
	// Device pins
	input  wire logic        RESET_N_PIN,
	input  wire logic        POWER_DOWN_N_PIN,
	input  wire logic        SLOT_INPUT_STROBE,
	// Serial frame timing
	input  wire logic        BUS_MASTER,
	input  wire logic        SLOT0_START,
	input  wire logic        SLOT1_START,
	input  wire logic        GENERATOR_ONE_ENABLE,
	// Control word access
	input  wire logic        CTRL_WR,
	input  wire logic        CTRL_RD,
	input  wire logic [5:0]  CTRL_ADDR,
	input  wire logic [15:0] CTRL_WDATA,
	output logic      [15:0] CTRL_RDATA,
	output logic             CTRL_RVALID,
	output logic      [15:0] SLOT1_DATA,
	output logic             SLOT1_VALID,
	// Generator one decode
	output logic             GEN1_REF_IS_SYNC,
	output logic             GEN1_VIDEO_LOCK,
	output logic             GEN1_PAL_LOCK,
	output logic             GEN1_LOOP_GAIN_HIGH,
	output logic             GEN1_BITCLK_ON,
	output logic      [15:0] GEN1_BITCLK_HZ,
	output logic             GEN1_BITCLK_X128,
	output logic      [15:0] GEN1_CONV_HZ,
	output logic      [3:0]  GEN1_CONV_DIVISOR,
	output logic             GEN1_CONV_X8_7,
	output logic             GEN1_CONV_PIN_X128,
	output logic             GEN1_PHASE_STEP,
	output logic             GEN1_PHASE_RETARD,
	// Generator two mode
	output logic      [15:0] GEN2_MODE
);
	typedef enum logic [1:0] {
		RB_IDLE       = 2'b00,
		RB_WAIT_FRAME = 2'b01,
		RB_WAIT_SLOT  = 2'b10
	} scg_readback_type;

	scg_phase_if phase_if ();

	logic [2:0]       sync_reference_input;
	logic [2:0]       sync2;
	logic             tsi_last;
	logic             hold;
	logic             phase_hold;
	logic             frame_start;
	logic             wr_ok;
	logic [15:0]      gen1_mode_control;
	logic [15:0]      gen1_sample_rate_word;
	logic [15:0]      gen2_mode_control;
	logic [15:0]      phase_snapshot;
	logic [15:0]      current;
	logic [15:0]      readback;
	logic             video;
	scg_readback_type rb_state;

	// Pins pass two flip-flops; the strobe edge is taken after the second
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			sync_reference_input    <= 3'b000;
			sync2    <= 3'b000;
			tsi_last <= 1'b0;
		end else begin
			sync_reference_input    <= {SLOT_INPUT_STROBE, POWER_DOWN_N_PIN, RESET_N_PIN};
			sync2    <= sync_reference_input;
			tsi_last <= sync2[2];
		end
	end

	assign hold        = !sync2[0] || !sync2[1];
	assign phase_hold  = hold || !GENERATOR_ONE_ENABLE;
	assign frame_start = BUS_MASTER ? SLOT0_START : (sync2[2] && !tsi_last);
	assign wr_ok       = CTRL_WR && !hold;
	assign video       = gen1_mode_control[scg_pkg::BIT_REF] &&
		gen1_mode_control[scg_pkg::BIT_VID];

	// Mode and rate registers
	always_ff @(posedge MCLK) begin
		if (SYS_RST || hold) begin
			gen1_mode_control <= scg_pkg::GEN1_MODE_RESET;
		end else if (wr_ok && CTRL_ADDR == scg_pkg::ADDR_GEN1_MODE) begin
			gen1_mode_control <= CTRL_WDATA & scg_pkg::MODE_WRITE_MASK;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST || hold) begin
			gen1_sample_rate_word <= scg_pkg::GEN1_RATE_RESET;
		end else if (wr_ok && CTRL_ADDR == scg_pkg::ADDR_GEN1_RATE) begin
			gen1_sample_rate_word <= CTRL_WDATA;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST || hold) begin
			gen2_mode_control <= scg_pkg::GEN2_MODE_RESET;
		end else if (wr_ok && CTRL_ADDR == scg_pkg::ADDR_GEN2_MODE) begin
			gen2_mode_control <= CTRL_WDATA & scg_pkg::MODE_WRITE_MASK;
		end
	end

	// Phase shift is loaded into the stepper; read shows the frame snapshot
	assign phase_if.clear    = SYS_RST || phase_hold;
	assign phase_if.load     = CTRL_WR && CTRL_ADDR == scg_pkg::ADDR_GEN1_PHASE;
	assign phase_if.load_dir = CTRL_WDATA[scg_pkg::BIT_PHDIR];
	assign phase_if.load_mag = CTRL_WDATA[7:0];

	scg_step_tick i_scg_step_tick (
		.clk (MCLK),
		.rst (SYS_RST),
		.t   (phase_if.ticker)
	);

	scg_phase_stepper i_scg_phase_stepper (
		.clk (MCLK),
		.rst (SYS_RST),
		.p   (phase_if.stepper)
	);

	always_ff @(posedge MCLK) begin
		if (SYS_RST || phase_hold) begin
			phase_snapshot <= scg_pkg::GEN1_PHASE_RESET;
		end else if (frame_start) begin
			phase_snapshot <= {7'h00, phase_if.dir, phase_if.mag};
		end
	end

	// Phase steps act only with the master clock reference
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			GEN1_PHASE_STEP   <= 1'b0;
			GEN1_PHASE_RETARD <= 1'b0;
		end else begin
			GEN1_PHASE_STEP   <= phase_if.step &&
				!gen1_mode_control[scg_pkg::BIT_REF];
			GEN1_PHASE_RETARD <= phase_if.dir;
		end
	end

	// Register read and prior-contents capture
	always_comb begin
		unique case (CTRL_ADDR)
			scg_pkg::ADDR_GEN1_MODE:  current = gen1_mode_control;
			scg_pkg::ADDR_GEN1_RATE:  current = gen1_sample_rate_word;
			scg_pkg::ADDR_GEN1_PHASE: current = phase_snapshot;
			scg_pkg::ADDR_GEN2_MODE:  current = gen2_mode_control;
			default:                  current = 16'h0000;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			CTRL_RDATA  <= 16'h0000;
			CTRL_RVALID <= 1'b0;
		end else begin
			CTRL_RDATA  <= CTRL_RD ? current : 16'h0000;
			CTRL_RVALID <= CTRL_RD;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			rb_state    <= RB_IDLE;
			readback    <= 16'h0000;
			SLOT1_DATA  <= 16'h0000;
			SLOT1_VALID <= 1'b0;
		end else begin
			SLOT1_VALID <= 1'b0;
			if (CTRL_WR) begin
				rb_state <= RB_WAIT_FRAME;
				readback <= current;
			end else begin
				unique case (rb_state)
					RB_IDLE: begin
					end
					RB_WAIT_FRAME: begin
						if (frame_start) begin
							rb_state <= RB_WAIT_SLOT;
						end
					end
					RB_WAIT_SLOT: begin
						if (SLOT1_START) begin
							rb_state    <= RB_IDLE;
							SLOT1_DATA  <= readback;
							SLOT1_VALID <= 1'b1;
						end
					end
					default: rb_state <= RB_IDLE;
				endcase
			end
		end
	end

	// Mode decode
	function automatic logic [15:0] video_base(input logic [7:0] m);
		logic [15:0] b;
		b = 16'h0000;
		unique case (m[6:4])
			3'b000:  b = scg_pkg::BASE_48000;
			3'b001:  b = scg_pkg::BASE_32000;
			3'b010:  b = scg_pkg::BASE_44100;
			3'b011:  b = scg_pkg::BASE_29400;
			3'b100:  b = m[scg_pkg::BIT_PAL] ? 16'h0000 : scg_pkg::BASE_48000;
			3'b101:  b = m[scg_pkg::BIT_PAL] ? 16'h0000 : scg_pkg::BASE_44056;
			default: b = 16'h0000;
		endcase
		return b;
	endfunction

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			GEN1_REF_IS_SYNC    <= 1'b0;
			GEN1_VIDEO_LOCK     <= 1'b0;
			GEN1_PAL_LOCK       <= 1'b0;
			GEN1_LOOP_GAIN_HIGH <= 1'b0;
			GEN1_CONV_PIN_X128  <= 1'b0;
			GEN2_MODE           <= scg_pkg::GEN2_MODE_RESET;
		end else begin
			GEN1_REF_IS_SYNC    <= gen1_mode_control[scg_pkg::BIT_REF];
			GEN1_VIDEO_LOCK     <= video;
			GEN1_PAL_LOCK       <= video && gen1_mode_control[scg_pkg::BIT_PAL];
			GEN1_LOOP_GAIN_HIGH <= gen1_mode_control[scg_pkg::BIT_PLLG];
			GEN1_CONV_PIN_X128  <= gen1_mode_control[scg_pkg::BIT_C128];
			GEN2_MODE           <= gen2_mode_control;
		end
	end

	// Bit clock
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			GEN1_BITCLK_ON   <= 1'b0;
			GEN1_BITCLK_HZ   <= 16'h0000;
			GEN1_BITCLK_X128 <= 1'b0;
		end else begin
			GEN1_BITCLK_ON   <= !video;
			GEN1_BITCLK_X128 <= !video && gen1_mode_control[7:4] == scg_pkg::NIBBLE_ONES &&
				gen1_mode_control[3:0] == scg_pkg::NIBBLE_ONES;
			if (video || gen1_mode_control[3:0] > scg_pkg::BITCLK_TOP) begin
				GEN1_BITCLK_HZ <= 16'h0000;
			end else begin
				GEN1_BITCLK_HZ <= ({12'h000, gen1_mode_control[3:0]} + 16'h0001) *
					scg_pkg::BITCLK_STEP_HZ +
					(gen1_mode_control[scg_pkg::BIT_P200] ? scg_pkg::BITCLK_PLUS_HZ :
					16'h0000);
			end
		end
	end

	// Conversion clock
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			GEN1_CONV_HZ      <= scg_pkg::GEN1_RATE_RESET;
			GEN1_CONV_DIVISOR <= 4'h1;
			GEN1_CONV_X8_7    <= 1'b0;
		end else if (video) begin
			GEN1_CONV_HZ      <= video_base(gen1_mode_control[7:0]);
			GEN1_CONV_DIVISOR <= gen1_mode_control[3:0] > scg_pkg::DIV_TOP ? 4'h0 :
				gen1_mode_control[3:0] + 4'h1;
			GEN1_CONV_X8_7    <= 1'b0;
		end else if (gen1_mode_control[scg_pkg::BIT_REF]) begin
			GEN1_CONV_HZ      <= gen1_mode_control[7:4] > scg_pkg::NORMAL_TOP ? 16'h0000 :
				scg_pkg::NORMAL_HZ[gen1_mode_control[7:4]];
			GEN1_CONV_DIVISOR <= 4'h1;
			GEN1_CONV_X8_7    <= gen1_mode_control[7:4] >= scg_pkg::NORMAL_X87 &&
				gen1_mode_control[7:4] <= scg_pkg::NORMAL_TOP;
		end else begin
			GEN1_CONV_HZ      <= gen1_sample_rate_word;
			GEN1_CONV_DIVISOR <= 4'h1;
			GEN1_CONV_X8_7    <= gen1_mode_control[scg_pkg::BIT_X87];
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SYS_RST);

	property p_mode_hold;
		hold |=> gen1_mode_control == 16'h00ff ##1 gen1_mode_control == 16'h00ff || !$past(hold);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode not held");

	property p_rate_hold;
		hold && CTRL_WR |=> gen1_sample_rate_word == 16'hbb80;
	endproperty
	a_rate_hold: assert property (p_rate_hold) else $error("rate not held");

	property p_phase_hold;
		!GENERATOR_ONE_ENABLE |=> phase_if.mag == 8'h00 && phase_snapshot == 16'h0000;
	endproperty
	a_phase_hold: assert property (p_phase_hold) else $error("phase not cleared");
	property p_plus200;
		gen1_mode_control == 16'h100b |=> GEN1_BITCLK_HZ == 16'h7148;
	endproperty
	a_plus200: assert property (p_plus200) else $error("plus 200 wrong");
	property p_x128;
		!video && gen1_mode_control[7:0] == 8'hff |=> GEN1_BITCLK_X128 && GEN1_BITCLK_ON;
	endproperty
	a_x128: assert property (p_x128) else $error("x128 missing");
	property p_video_ntsc;
		gen1_mode_control == 16'hc044 |=> GEN1_CONV_HZ == 16'hbb80 && GEN1_CONV_DIVISOR == 4'h5
			&& !GEN1_BITCLK_ON && !GEN1_PAL_LOCK;
	endproperty
	a_video_ntsc: assert property (p_video_ntsc) else $error("ntsc decode wrong");
	property p_video_pal;
		gen1_mode_control == 16'hc0a3 |=> GEN1_CONV_HZ == 16'hac44 && GEN1_CONV_DIVISOR == 4'h4
			&& GEN1_PAL_LOCK;
	endproperty
	a_video_pal: assert property (p_video_pal) else $error("pal decode wrong");
	property p_rate_word;
		!gen1_mode_control[scg_pkg::BIT_REF] |=> GEN1_CONV_HZ == $past(gen1_sample_rate_word);
	endproperty
	a_rate_word: assert property (p_rate_word) else $error("rate word not used");
	property p_snapshot;
		frame_start && !phase_hold |=> phase_snapshot[8:0] == $past({phase_if.dir, phase_if.mag});
	endproperty
	a_snapshot: assert property (p_snapshot) else $error("phase snapshot wrong");
	property p_readback;
		rb_state == RB_WAIT_SLOT && SLOT1_START && !CTRL_WR |=> SLOT1_VALID
			&& SLOT1_DATA == $past(readback);
	endproperty
	a_readback: assert property (p_readback) else $error("slot 1 readback missing");

	c_video: cover property (GEN1_VIDEO_LOCK && GEN1_PAL_LOCK);
	c_step: cover property (GEN1_PHASE_STEP && GEN1_PHASE_RETARD);
	c_readback: cover property (SLOT1_VALID);
endmodule
`default_nettype wire

// File: dv/scg_host_model.sv
// Host side frame timing: slot starts when master, slot-input strobe when slave
`timescale 1ns/1ps
`default_nettype none
module scg_host_model #(
	parameter int FRAME = 40
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Frame timing
	output logic      slot0_start,
	output logic      slot1_start,
	output logic      strobe
);
	int cnt;

	initial begin
		cnt = 0;
		slot0_start = 1'b0;
		slot1_start = 1'b0;
		strobe = 1'b0;
	end

	// Frame start always comes before slot 1; strobe is high for counts 1 and 2 only, rising at the same count as slot 0 start
	always @(negedge clk) begin
		cnt = rst ? 0 : (cnt + 1) % FRAME;
		slot0_start <= (cnt == 1);
		slot1_start <= (cnt == 5);
		strobe <= (cnt >= 1) && (cnt < 3);
	end
endmodule
`default_nettype wire

// File: dv/test_scg_generator_ctrl.sv
// Self-checking bench for the generator one control block
`timescale 1ns/1ps
`default_nettype none
module test_scg_generator_ctrl;
	typedef struct packed {
		logic [15:0] mode;
		logic [15:0] conv;
		logic [15:0] bitclk;
		logic [3:0]  div;
	} scg_row_type;
	localparam logic [5:0] A_MODE  = scg_pkg::ADDR_GEN1_MODE;
	localparam logic [5:0] A_RATE  = scg_pkg::ADDR_GEN1_RATE;
	localparam logic [5:0] A_PHASE = scg_pkg::ADDR_GEN1_PHASE;
	localparam logic [5:0] A_GEN2  = scg_pkg::ADDR_GEN2_MODE;
	localparam int         LIMIT   = 10000;
	// Ordinary decode cases, chosen within supported pairs
	localparam scg_row_type ROWS [0:9] = '{
		'{16'h0000, 16'hbb80, 16'h0960, 4'h1}, '{16'h100b, 16'hbb80, 16'h7148, 4'h1},
		'{16'h00ff, 16'hbb80, 16'h0000, 4'h1}, '{16'h8005, 16'h1c20, 16'h3840, 4'h1},
		'{16'hc000, 16'hbb80, 16'h0000, 4'h1}, '{16'hc0a3, 16'hac44, 16'h0000, 4'h4},
		'{16'hc030, 16'h72d8, 16'h0000, 4'h1}, '{16'hc044, 16'hbb80, 16'h0000, 4'h5},
		'{16'hc057, 16'hac18, 16'h0000, 4'h8}, '{16'hc011, 16'h7d00, 16'h0000, 4'h2}};
	logic        mclk, sys_rst, reset_n, pdn_n, bus_master, g1_en;
	logic        slot0, slot1, strobe, ctrl_wr, ctrl_rd, rvalid, s1_valid;
	logic [5:0]  ctrl_addr;
	logic [15:0] ctrl_wdata, rdata, s1_data, bit_hz, conv_hz, gen2, steps, m;
	logic        ref_sync, vid, pal, gain, bit_on, x128, x87, pin128, step, retard;
	logic [3:0]  div;
	int          errors, n_tests, cycles, k;

	scg_generator_ctrl i_scg_generator_ctrl (
		.MCLK(mclk), .SYS_RST(sys_rst), .RESET_N_PIN(reset_n), .POWER_DOWN_N_PIN(pdn_n),
		.SLOT_INPUT_STROBE(strobe), .BUS_MASTER(bus_master), .SLOT0_START(slot0),
		.SLOT1_START(slot1), .GENERATOR_ONE_ENABLE(g1_en), .CTRL_WR(ctrl_wr),
		.CTRL_RD(ctrl_rd), .CTRL_ADDR(ctrl_addr), .CTRL_WDATA(ctrl_wdata),
		.CTRL_RDATA(rdata), .CTRL_RVALID(rvalid), .SLOT1_DATA(s1_data),
		.SLOT1_VALID(s1_valid), .GEN1_REF_IS_SYNC(ref_sync), .GEN1_VIDEO_LOCK(vid),
		.GEN1_PAL_LOCK(pal), .GEN1_LOOP_GAIN_HIGH(gain), .GEN1_BITCLK_ON(bit_on),
		.GEN1_BITCLK_HZ(bit_hz), .GEN1_BITCLK_X128(x128), .GEN1_CONV_HZ(conv_hz),
		.GEN1_CONV_DIVISOR(div), .GEN1_CONV_X8_7(x87), .GEN1_CONV_PIN_X128(pin128),
		.GEN1_PHASE_STEP(step), .GEN1_PHASE_RETARD(retard), .GEN2_MODE(gen2));

	scg_host_model i_scg_host_model (
		.clk(mclk), .rst(sys_rst), .slot0_start(slot0), .slot1_start(slot1),
		.strobe(strobe));

	initial begin
		mclk = 1'b0;
		sys_rst = 1'b1;
		reset_n = 1'b1;
		pdn_n = 1'b1;
		bus_master = 1'b1;
		g1_en = 1'b1;
		ctrl_wr = 1'b0;
		ctrl_rd = 1'b0;
		ctrl_addr = 6'h00;
		ctrl_wdata = 16'h0000;
		steps = 16'h0000;
		errors = 0;
		n_tests = 0;
		cycles = 0;
	end

	always #2.5 mclk = ~mclk;

	// Counted at the falling edge, where the step pulse has settled
	always @(negedge mclk) begin
		if (step === 1'b1) begin
			steps <= steps + 16'h0001;
		end
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(negedge mclk);
		ctrl_wr = 1'b1;
		ctrl_addr = a;
		ctrl_wdata = d;
		@(negedge mclk);
		ctrl_wr = 1'b0;
	endtask

	// Read answer stands for the cycle after the strobe is taken
	task automatic rchk(input logic [5:0] a, input logic [15:0] exp);
		@(negedge mclk);
		ctrl_rd = 1'b1;
		ctrl_addr = a;
		@(negedge mclk);
		ctrl_rd = 1'b0;
		chk({15'h0000, rvalid}, 16'h0001);
		chk(rdata, exp);
	endtask

	initial begin
		cyc(6);
		sys_rst = 1'b0;
		cyc(4);
		rchk(A_MODE, 16'h00ff);
		rchk(A_RATE, 16'hbb80);
		rchk(A_PHASE, 16'h0000);
		rchk(6'h14, 16'h0000);
		$display("test reset_values done");
		for (int i = 0; i < 10; i++) begin
			m = ROWS[i].mode;
			wr(A_MODE, m);
			cyc(3);
			chk(conv_hz, ROWS[i].conv);
			chk(bit_hz, ROWS[i].bitclk);
			chk({12'h000, div}, {12'h000, ROWS[i].div});
			chk({12'h000, ref_sync, vid, pal, bit_on},
				{12'h000, m[15], m[15] & m[14], m[15] & m[14] & m[7], ~(m[15] & m[14])});
			chk({15'h0000, x128}, {15'h0000, (m[7:0] == 8'hff) & ~(m[15] & m[14])});
			rchk(A_MODE, m);
		end
		$display("test decode_rows done");
		wr(A_MODE, 16'h0800);
		foreach (ROWS[i]) begin
			m = (i % 2 == 0) ? 16'h0fa0 : 16'hd2f0;
			wr(A_RATE, m);
			cyc(3);
			chk(conv_hz, m);
			chk({15'h0000, x87}, 16'h0001);
		end
		$display("test rate_word done");
		wr(A_MODE, 16'h0000);
		steps = 16'h0000;
		wr(A_PHASE, 16'h0105);
		cyc(600);
		chk(steps, 16'h0005);
		chk({15'h0000, retard}, 16'h0001);
		rchk(A_PHASE, 16'h0100);
		wr(A_PHASE, 16'h00ff);
		cyc(200);
		wr(A_PHASE, 16'h0002);
		cyc(400);
		rchk(A_PHASE, 16'h0000);
		chk({15'h0000, retard}, 16'h0000);
		wr(A_MODE, 16'h8000);
		steps = 16'h0000;
		wr(A_PHASE, 16'h0003);
		cyc(400);
		chk(steps, 16'h0000);
		g1_en = 1'b0;
		wr(A_PHASE, 16'h0010);
		cyc(50);
		rchk(A_PHASE, 16'h0000);
		g1_en = 1'b1;
		$display("test phase done");
		for (int i = 0; i < 2; i++) begin
			wr(A_RATE, 16'h0fa0);
			if (i == 0) pdn_n = 1'b0;
			else reset_n = 1'b0;
			cyc(4);
			wr(A_RATE, 16'h1234);
			wr(A_MODE, 16'h1234);
			rchk(A_RATE, 16'hbb80);
			rchk(A_MODE, 16'h00ff);
			pdn_n = 1'b1;
			reset_n = 1'b1;
			cyc(4);
		end
		$display("test pin_hold done");
		for (int i = 0; i < 2; i++) begin
			bus_master = (i == 0);
			m = (i == 0) ? 16'hbb80 : 16'h1f40;
			wr(A_RATE, (i == 0) ? 16'h1f40 : 16'h3e80);
			k = 0;
			while (s1_valid !== 1'b1 && k < 200) begin
				@(negedge mclk);
				k++;
			end
			chk({15'h0000, s1_valid}, 16'h0001);
			chk(s1_data, m);
		end
		bus_master = 1'b1;
		$display("test slot1_readback done");
		wr(A_GEN2, 16'hffff);
		cyc(3);
		chk(gen2, 16'hfcff);
		rchk(A_GEN2, 16'hfcff);
		wr(A_MODE, 16'ha4a5);
		cyc(3);
		chk(conv_hz, 16'h2ee0);
		chk(bit_hz, 16'h3840);
		chk({13'h0000, x87, gain, pin128}, 16'h0007);
		wr(6'h14, 16'h5555);
		rchk(6'h14, 16'h0000);
		sys_rst = 1'b1;
		cyc(2);
		sys_rst = 1'b0;
		cyc(4);
		rchk(A_GEN2, 16'h00ff);
		rchk(A_RATE, 16'hbb80);
		$display("test gen2_and_rerun done");
		end_of_test();
	end
endmodule
`default_nettype wire
